// >>> hdl/dtc_timers.sv
// dtc_timers: control, hold and capture registers of the byte/word timer pair
//
// Operation
// RL1: byte capture high holds byte count gathered while input was one.
// RL2: byte capture low holds byte count gathered while input was zero.
// RL3: word capture split into upper byte and lower byte registers.
// RL4: capture registers read captured data; writes to them are ignored.
// RL5: run bit written one starts, zero stops; read shows run state.
// RL6: repeat bit zero reloads at terminal count, one stops there.
// RL7: timeout flag set at terminal count, cleared only by writing one.
// RL8: software clears timeout flag by writing one before using timers.
// RL9: prescale field picks clock, half, quarter or eighth of clock.
// RL10: first prescaled tick after enable may come early, unaligned.
// RL11: capture mask one requests interrupt on each demodulation capture.
// RL12: timeout mask one requests interrupt on each byte timer timeout.
// RL13: route bit picks port latch or byte timer onto first pin.
// RL14: power-on clears all fields; stop recovery keeps marked fields.
// RL15: software avoids read-modify-write on timeout and edge flags.
// RL16: mode bit zero is transmit, one is demodulation.
// RL17: select bit drives third pin, or picks comparator or port2 input.
// RL18: combine field is AND/OR/NOR/NAND, or edge select in demodulation.
// RL19: submode field normal/ping-pong/force low/high, or glitch filter; the code drives ping-pong code 1 the same as normal.
// RL20: bit one is byte start level, or rise flag cleared by one.
// RL21: bit zero is word start level, or fall flag cleared by one.
// RL22: registers appear in low locations when pointer low nibble is D.
// RL23: pointer nibble zero is normal file; nonzero swaps low 16.
// RL24: a flag set in the cycle of its clear stays set.
`timescale 1ns/1ps
module dtc_timers (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic STOP_RECOVER,
  input wire logic [7:0] REG_PTR,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic EXP_BANK_SWAP,
  output logic TIMER_BANK_SEL,
  input wire logic WORD_RUN,
  input wire logic COMPARATOR_INPUT_PIN,
  input wire logic PORT2_INPUT_PIN,
  input wire logic PORT_LATCH_FIRST,
  input wire logic PORT_LATCH_THIRD,
  output logic FIRST_OUTPUT_PIN,
  output logic THIRD_OUTPUT_PIN,
  output logic BYTE_TIMER_OUT,
  output logic WORD_TIMER_OUT,
  output logic CAPTURE_IRQ,
  output logic TIMEOUT_IRQ
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic [7:0] ctrl0_q, ctrl0_d, ctrl1_q, ctrl1_d;
  logic [7:0] b_low_q, b_high_q, w_low_q, w_high_q;
  logic [7:0] bcap_lo_q, bcap_hi_q, wcap_lo_q, wcap_hi_q;
  logic [7:0] bcnt_q;
  logic [15:0] wcnt_q;
  logic bout_q, wout_q, brun_prev_q, wrun_prev_q;
  logic comp_s1_q, comp_s2_q, p2_s1_q, p2_s2_q;
  logic filt_q, filt_prev_q;
  logic [3:0] filt_cnt_q, filt_lim;
  logic hit, wr0, wr1, demod, brun, bstart, wstart, btick, raw_in;
  logic rise_det, fall_det, rise_en, fall_en, edge_en, cap_evt, to_evt;
  logic w_eff, comb;
  logic [1:0] cfield, sfield;

  // ************************************************************
  // bank decode
  // ************************************************************
  // only the low sixteen locations are swapped, whatever the bank
  always_comb begin
    EXP_BANK_SWAP = (REG_PTR[3:0] != dtc_pkg::BANK_NORMAL) &&
                    (REG_ADDR[7:4] == dtc_pkg::LOW_GROUP); // RL23
    hit = (REG_PTR[3:0] == dtc_pkg::BANK_TIMERS) &&
          (REG_ADDR[7:4] == dtc_pkg::LOW_GROUP); // RL22
    TIMER_BANK_SEL = hit;
    wr0 = REG_WR && hit && (REG_ADDR[3:0] == dtc_pkg::OFF_CTRL0);
    wr1 = REG_WR && hit && (REG_ADDR[3:0] == dtc_pkg::OFF_CTRL1);
  end

  // field views used all over the block
  always_comb begin
    demod = ctrl1_q[dtc_pkg::C1_MODE]; // RL16
    brun = ctrl0_q[dtc_pkg::C0_RUN];
    bstart = brun && !brun_prev_q;
    wstart = WORD_RUN && !wrun_prev_q;
    cfield = ctrl1_q[dtc_pkg::C1_COMB_HI:dtc_pkg::C1_COMB_LO];
    sfield = ctrl1_q[dtc_pkg::C1_SUB_HI:dtc_pkg::C1_SUB_LO];
  end

  // ************************************************************
  // control registers
  // ************************************************************
  // hardware sets are applied after the write so a set beats a clear
  always_comb begin
    ctrl0_d = ctrl0_q;
    if (wr0) begin
      ctrl0_d = REG_WDATA; // RL5
      ctrl0_d[dtc_pkg::C0_TIMEOUT] = ctrl0_q[dtc_pkg::C0_TIMEOUT] &
                                     ~REG_WDATA[dtc_pkg::C0_TIMEOUT]; // RL7
    end
    if (to_evt && ctrl0_q[dtc_pkg::C0_SINGLE] && !wr0) begin
      ctrl0_d[dtc_pkg::C0_RUN] = 1'b0; // RL6
    end
    if (to_evt) begin
      ctrl0_d[dtc_pkg::C0_TIMEOUT] = 1'b1; // RL24
    end
  end

  // in demodulation the two low bits are flags cleared by a one
  always_comb begin
    ctrl1_d = ctrl1_q;
    if (wr1) begin
      ctrl1_d = REG_WDATA;
      if (demod) begin
        ctrl1_d[dtc_pkg::C1_LVLA] = ctrl1_q[dtc_pkg::C1_LVLA] &
                                    ~REG_WDATA[dtc_pkg::C1_LVLA]; // RL20
        ctrl1_d[dtc_pkg::C1_LVLB] = ctrl1_q[dtc_pkg::C1_LVLB] &
                                    ~REG_WDATA[dtc_pkg::C1_LVLB]; // RL21
      end
    end
    if (rise_en) begin
      ctrl1_d[dtc_pkg::C1_LVLA] = 1'b1; // RL24
    end
    if (fall_en) begin
      ctrl1_d[dtc_pkg::C1_LVLB] = 1'b1; // RL24
    end
  end

  // stop recovery keeps only the marked fields
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ctrl0_q <= dtc_pkg::CTRL_RESET; // RL14
      ctrl1_q <= dtc_pkg::CTRL_RESET;
    end else if (STOP_RECOVER) begin
      ctrl0_q <= ctrl0_q & dtc_pkg::KEEP0_MASK; // RL14
      ctrl1_q <= ctrl1_q & dtc_pkg::KEEP1_MASK;
    end else begin
      ctrl0_q <= ctrl0_d;
      ctrl1_q <= ctrl1_d;
    end
  end

  // reload values change any time; they only act when next loaded
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      b_low_q <= dtc_pkg::DATA_RESET;
      b_high_q <= dtc_pkg::DATA_RESET;
      w_low_q <= dtc_pkg::DATA_RESET;
      w_high_q <= dtc_pkg::DATA_RESET;
    end else if (REG_WR && hit) begin
      if (REG_ADDR[3:0] == dtc_pkg::OFF_B_LOW) begin
        b_low_q <= REG_WDATA;
      end else if (REG_ADDR[3:0] == dtc_pkg::OFF_B_HIGH) begin
        b_high_q <= REG_WDATA;
      end else if (REG_ADDR[3:0] == dtc_pkg::OFF_W_LOW) begin
        w_low_q <= REG_WDATA;
      end else if (REG_ADDR[3:0] == dtc_pkg::OFF_W_HIGH) begin
        w_high_q <= REG_WDATA;
      end
    end
  end

  // ************************************************************
  // read port
  // ************************************************************
  // unmapped offsets read zero; capture writes are never decoded
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      REG_RDATA <= dtc_pkg::DATA_RESET;
    end else if (REG_RD && hit) begin
      if (REG_ADDR[3:0] == dtc_pkg::OFF_CTRL0) begin
        REG_RDATA <= ctrl0_q; // RL5
      end else if (REG_ADDR[3:0] == dtc_pkg::OFF_CTRL1) begin
        REG_RDATA <= ctrl1_q;
      end else if (REG_ADDR[3:0] == dtc_pkg::OFF_B_LOW) begin
        REG_RDATA <= b_low_q;
      end else if (REG_ADDR[3:0] == dtc_pkg::OFF_B_HIGH) begin
        REG_RDATA <= b_high_q;
      end else if (REG_ADDR[3:0] == dtc_pkg::OFF_W_LOW) begin
        REG_RDATA <= w_low_q;
      end else if (REG_ADDR[3:0] == dtc_pkg::OFF_W_HIGH) begin
        REG_RDATA <= w_high_q;
      end else if (REG_ADDR[3:0] == dtc_pkg::OFF_WCAP_LO) begin
        REG_RDATA <= wcap_lo_q; // RL4
      end else if (REG_ADDR[3:0] == dtc_pkg::OFF_WCAP_HI) begin
        REG_RDATA <= wcap_hi_q;
      end else if (REG_ADDR[3:0] == dtc_pkg::OFF_BCAP_LO) begin
        REG_RDATA <= bcap_lo_q;
      end else if (REG_ADDR[3:0] == dtc_pkg::OFF_BCAP_HI) begin
        REG_RDATA <= bcap_hi_q;
      end else begin
        REG_RDATA <= dtc_pkg::DATA_RESET;
      end
    end
  end

  // ************************************************************
  // input path: synchroniser, glitch filter, edge detect
  // ************************************************************
  // pins are asynchronous, two flops each before anything looks
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      comp_s1_q <= 1'b0;
      comp_s2_q <= 1'b0;
      p2_s1_q <= 1'b0;
      p2_s2_q <= 1'b0;
    end else begin
      comp_s1_q <= COMPARATOR_INPUT_PIN;
      comp_s2_q <= comp_s1_q;
      p2_s1_q <= PORT2_INPUT_PIN;
      p2_s2_q <= p2_s1_q;
    end
  end

  always_comb begin
    raw_in = ctrl1_q[dtc_pkg::C1_SEL] ? p2_s2_q : comp_s2_q; // RL17
    if (sfield == dtc_pkg::FILT_NONE) begin
      filt_lim = dtc_pkg::FILT_NONE_CYC; // RL19
    end else if (sfield == dtc_pkg::FILT_4) begin
      filt_lim = dtc_pkg::FILT_4_CYC;
    end else begin
      filt_lim = dtc_pkg::FILT_8_CYC;
    end
  end

  // a level change is accepted once it has held for the filter length
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      filt_q <= 1'b0;
      filt_prev_q <= 1'b0;
      filt_cnt_q <= '0;
    end else begin
      filt_prev_q <= filt_q;
      if (raw_in == filt_q) begin
        filt_cnt_q <= '0;
      end else if (filt_cnt_q + 4'h1 >= filt_lim) begin
        filt_q <= raw_in; // RL19
        filt_cnt_q <= '0;
      end else begin
        filt_cnt_q <= filt_cnt_q + 4'h1;
      end
    end
  end

  // edge select only counts in demodulation; code three detects nothing
  always_comb begin
    rise_det = filt_q && !filt_prev_q;
    fall_det = !filt_q && filt_prev_q;
    rise_en = demod && rise_det &&
              (cfield == dtc_pkg::EDGE_RISE ||
               cfield == dtc_pkg::EDGE_BOTH); // RL18
    fall_en = demod && fall_det &&
              (cfield == dtc_pkg::EDGE_FALL ||
               cfield == dtc_pkg::EDGE_BOTH); // RL18
    edge_en = rise_en || fall_en;
    cap_evt = edge_en && brun;
    to_evt = brun && !bstart && !demod && btick && (bcnt_q == 8'h00);
  end

  // ************************************************************
  // byte timer
  // ************************************************************
  dtc_prescale #(
    .DIV_BITS(3)
  ) u_prescale (
    .clk(CORE_CLK),
    .rst(RST),
    .sel(ctrl0_q[dtc_pkg::C0_PRE_HI:dtc_pkg::C0_PRE_LO]), // RL9
    .tick(btick) // RL10
  );

  // transmit counts down between the two reload values; demodulation
  // counts up and restarts on every accepted edge
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      bcnt_q <= dtc_pkg::DATA_RESET;
      bout_q <= 1'b1;
      brun_prev_q <= 1'b0;
    end else begin
      brun_prev_q <= brun;
      if (!brun) begin
        bout_q <= ~ctrl1_q[dtc_pkg::C1_LVLA];
      end else if (bstart) begin
        bcnt_q <= dtc_pkg::DATA_RESET;
        if (!demod) begin
          bout_q <= ctrl1_q[dtc_pkg::C1_LVLA]; // RL20
          bcnt_q <= ctrl1_q[dtc_pkg::C1_LVLA] ? b_high_q : b_low_q;
        end
      end else if (demod) begin
        if (cap_evt) begin
          bcnt_q <= dtc_pkg::DATA_RESET;
        end else if (btick) begin
          bcnt_q <= bcnt_q + 8'h01;
        end
      end else if (to_evt) begin
        bout_q <= ~bout_q; // RL6
        bcnt_q <= bout_q ? b_low_q : b_high_q;
      end else if (btick) begin
        bcnt_q <= bcnt_q - 8'h01;
      end
    end
  end

  // ************************************************************
  // word timer
  // ************************************************************
  // runs on the undivided clock while enabled from its own control
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      wcnt_q <= '0;
      wout_q <= 1'b1;
      wrun_prev_q <= 1'b0;
    end else begin
      wrun_prev_q <= WORD_RUN;
      if (!WORD_RUN) begin
        wout_q <= ~ctrl1_q[dtc_pkg::C1_LVLB];
      end else if (wstart || (demod && edge_en)) begin
        wcnt_q <= '0;
        if (!demod) begin
          wout_q <= ctrl1_q[dtc_pkg::C1_LVLB]; // RL21
          wcnt_q <= {w_high_q, w_low_q};
        end
      end else if (demod) begin
        wcnt_q <= wcnt_q + 16'h0001;
      end else if (wcnt_q == 16'h0000) begin
        wout_q <= ~wout_q;
        wcnt_q <= {w_high_q, w_low_q};
      end else begin
        wcnt_q <= wcnt_q - 16'h0001;
      end
    end
  end

  // ************************************************************
  // captures
  // ************************************************************
  // a rising edge closes a low period, a falling edge a high period
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      bcap_lo_q <= dtc_pkg::DATA_RESET;
      bcap_hi_q <= dtc_pkg::DATA_RESET;
      wcap_lo_q <= dtc_pkg::DATA_RESET;
      wcap_hi_q <= dtc_pkg::DATA_RESET;
    end else begin
      if (cap_evt && rise_en) begin
        bcap_lo_q <= bcnt_q; // RL2
      end
      if (cap_evt && fall_en) begin
        bcap_hi_q <= bcnt_q; // RL1
      end
      if (edge_en && WORD_RUN) begin
        wcap_hi_q <= wcnt_q[15:8]; // RL3
        wcap_lo_q <= wcnt_q[7:0];
      end
    end
  end

  // ************************************************************
  // pins and interrupt requests
  // ************************************************************
  always_comb begin
    if (sfield == dtc_pkg::SUB_FORCE_LO) begin
      w_eff = 1'b0; // RL19
    end else if (sfield == dtc_pkg::SUB_FORCE_HI) begin
      w_eff = 1'b1;
    end else begin
      w_eff = wout_q;
    end
    case (cfield)
      dtc_pkg::COMB_AND: comb = bout_q & w_eff; // RL18
      dtc_pkg::COMB_OR: comb = bout_q | w_eff;
      dtc_pkg::COMB_NOR: comb = ~(bout_q | w_eff);
      default: comb = ~(bout_q & w_eff);
    endcase
  end

  // pins registered so they never glitch on a control write
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      FIRST_OUTPUT_PIN <= 1'b0;
      THIRD_OUTPUT_PIN <= 1'b0;
      BYTE_TIMER_OUT <= 1'b0;
      WORD_TIMER_OUT <= 1'b0;
      CAPTURE_IRQ <= 1'b0;
      TIMEOUT_IRQ <= 1'b0;
    end else begin
      FIRST_OUTPUT_PIN <= ctrl0_q[dtc_pkg::C0_ROUTE] ? bout_q
                          : PORT_LATCH_FIRST; // RL13
      THIRD_OUTPUT_PIN <= (!demod && ctrl1_q[dtc_pkg::C1_SEL]) ? comb
                          : PORT_LATCH_THIRD; // RL17
      BYTE_TIMER_OUT <= bout_q;
      WORD_TIMER_OUT <= w_eff;
      CAPTURE_IRQ <= cap_evt && ctrl0_q[dtc_pkg::C0_CAPMASK]; // RL11
      TIMEOUT_IRQ <= to_evt && ctrl0_q[dtc_pkg::C0_TOMASK]; // RL12
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  property p_cap_hi;
    cap_evt && fall_en |=> bcap_hi_q == $past(bcnt_q);
  endproperty
  a_cap_hi: assert property (p_cap_hi) else $error("high capture wrong"); // RL1

  property p_cap_lo;
    cap_evt && rise_en |=> bcap_lo_q == $past(bcnt_q);
  endproperty
  a_cap_lo: assert property (p_cap_lo) else $error("low capture wrong"); // RL2

  property p_word_split;
    edge_en && WORD_RUN |=> {wcap_hi_q, wcap_lo_q} == $past(wcnt_q);
  endproperty
  a_word_split: assert property (p_word_split) else $error("word split"); // RL3

  property p_cap_ro;
    REG_WR && hit && REG_ADDR[3:0] == dtc_pkg::OFF_BCAP_LO && !cap_evt
      |=> $stable(bcap_lo_q);
  endproperty
  a_cap_ro: assert property (p_cap_ro) else $error("capture written"); // RL4

  property p_stop;
    wr0 && !REG_WDATA[dtc_pkg::C0_RUN] && !STOP_RECOVER |=> !brun;
  endproperty
  a_stop: assert property (p_stop) else $error("timer not stopped"); // RL5

  property p_timeout;
    to_evt && !STOP_RECOVER |=> ctrl0_q[dtc_pkg::C0_TIMEOUT];
  endproperty
  a_timeout: assert property (p_timeout) else $error("flag lost"); // RL7

  property p_to_irq;
    to_evt |=> TIMEOUT_IRQ == $past(ctrl0_q[dtc_pkg::C0_TOMASK]);
  endproperty
  a_to_irq: assert property (p_to_irq) else $error("timeout irq"); // RL12

  property p_route;
    !ctrl0_q[dtc_pkg::C0_ROUTE] |=> FIRST_OUTPUT_PIN == $past(PORT_LATCH_FIRST);
  endproperty
  a_route: assert property (p_route) else $error("first pin route"); // RL13

  property p_smr;
    STOP_RECOVER |=> ctrl0_q[dtc_pkg::C0_PRE_HI:dtc_pkg::C0_PRE_LO] ==
      $past(ctrl0_q[dtc_pkg::C0_PRE_HI:dtc_pkg::C0_PRE_LO]) && !brun;
  endproperty
  a_smr: assert property (p_smr) else $error("stop recovery"); // RL14

  property p_rise;
    rise_en && !STOP_RECOVER |=> ctrl1_q[dtc_pkg::C1_LVLA];
  endproperty
  a_rise: assert property (p_rise) else $error("rise flag"); // RL20

  property p_bank;
    REG_PTR[3:0] == dtc_pkg::BANK_NORMAL |-> !EXP_BANK_SWAP && !hit;
  endproperty
  a_bank: assert property (p_bank) else $error("bank swap"); // RL23

  c_capture: cover property (cap_evt ##1 CAPTURE_IRQ);
  c_timeout: cover property (to_evt ##1 TIMEOUT_IRQ);
  c_recover: cover property (brun ##1 STOP_RECOVER);

endmodule : dtc_timers

// >>> hdl/dtc_pkg.sv
// dtc_pkg: offsets, field positions and codes of the dual timer control block
package dtc_pkg;

  // ************************************************************
  // bank decode
  // ************************************************************
  localparam logic [3:0] BANK_NORMAL = 4'h0;
  localparam logic [3:0] BANK_TIMERS = 4'hd;
  localparam logic [3:0] LOW_GROUP = 4'h0;

  // ************************************************************
  // register offsets inside the bank
  // ************************************************************
  localparam logic [3:0] OFF_CTRL0 = 4'h0;
  localparam logic [3:0] OFF_CTRL1 = 4'h1;
  localparam logic [3:0] OFF_B_LOW = 4'h4;
  localparam logic [3:0] OFF_B_HIGH = 4'h5;
  localparam logic [3:0] OFF_W_LOW = 4'h6;
  localparam logic [3:0] OFF_W_HIGH = 4'h7;
  localparam logic [3:0] OFF_WCAP_LO = 4'h8;
  localparam logic [3:0] OFF_WCAP_HI = 4'h9;
  localparam logic [3:0] OFF_BCAP_LO = 4'ha;
  localparam logic [3:0] OFF_BCAP_HI = 4'hb;

  // ************************************************************
  // byte timer control register fields
  // ************************************************************
  localparam int C0_RUN = 7;
  localparam int C0_SINGLE = 6;
  localparam int C0_TIMEOUT = 5;
  localparam int C0_PRE_HI = 4;
  localparam int C0_PRE_LO = 3;
  localparam int C0_CAPMASK = 2;
  localparam int C0_TOMASK = 1;
  localparam int C0_ROUTE = 0;

  // ************************************************************
  // shared timer control register fields
  // ************************************************************
  localparam int C1_MODE = 7;
  localparam int C1_SEL = 6;
  localparam int C1_COMB_HI = 5;
  localparam int C1_COMB_LO = 4;
  localparam int C1_SUB_HI = 3;
  localparam int C1_SUB_LO = 2;
  localparam int C1_LVLA = 1;
  localparam int C1_LVLB = 0;

  // ************************************************************
  // reset values and stop-recovery keep masks
  // ************************************************************
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] KEEP0_MASK = 8'h3e;
  localparam logic [7:0] KEEP1_MASK = 8'h30;

  // ************************************************************
  // field codes and filter lengths
  // ************************************************************
  localparam logic [1:0] COMB_AND = 2'h0;
  localparam logic [1:0] COMB_OR = 2'h1;
  localparam logic [1:0] COMB_NOR = 2'h2;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [1:0] SUB_FORCE_LO = 2'h2;
  localparam logic [1:0] SUB_FORCE_HI = 2'h3;
  localparam logic [1:0] FILT_NONE = 2'h0;
  localparam logic [1:0] FILT_4 = 2'h1;
  localparam logic [3:0] FILT_NONE_CYC = 4'h1;
  localparam logic [3:0] FILT_4_CYC = 4'h4;
  localparam logic [3:0] FILT_8_CYC = 4'h8;

endpackage : dtc_pkg

// >>> hdl/dtc_prescale.sv
// dtc_prescale: free-running divider that gives the byte timer its count tick
`timescale 1ns/1ps
module dtc_prescale #(
  parameter int DIV_BITS = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] sel,
  output logic tick
);

  logic [DIV_BITS-1:0] div_q;
  logic [DIV_BITS-1:0] mask;

  // divider never restarts on enable, so the first tick may come early
  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + {{(DIV_BITS-1){1'b0}}, 1'b1};
    end
  end

  // select 0..3 gives a tick every 1, 2, 4 or 8 clocks
  always_comb begin
    mask = ~({DIV_BITS{1'b1}} << sel);
    tick = ((div_q & mask) == mask);
  end

endmodule : dtc_prescale

// >>> verif/dtc_cpu.sv
// dtc_cpu: processor model reaching the timer bank through the pointer
`timescale 1ns/1ps
module dtc_cpu (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [7:0] ptr = 8'h0d,
  output logic [7:0] addr = 8'hff,
  output logic wr = 1'b0,
  output logic rd = 1'b0,
  output logic [7:0] wdata = 8'h00
);
  bit slow = 1'b0; // one idle cycle ahead of each access
  // strobe for one cycle; released lines invert so stale values show
  task automatic acc(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q);
    if (slow) @(posedge clk);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    @(posedge clk);
    #1;
    q = rdata;
    wr = 1'b0;
    rd = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask : acc
endmodule : dtc_cpu

// >>> verif/dual_timer_control_capture_regs_tb.sv
// dual_timer_control_capture_regs_tb: self-checking bench of the timer bank
`timescale 1ns/1ps
module dual_timer_control_capture_regs_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic stop = 1'b0;
  logic cmp_in = 1'b0;
  logic p2_in = 1'b0;
  logic [7:0] ptr, addr, wdata, rdata;
  logic wr, rd, swap, tsel, pin1, bout, cirq, tirq, wout, pin3;
  logic lat3 = 1'b1; // differs from the forced combined level below
  int err_count = 0;
  int cmp_count = 0;
  int tcnt = 0;
  int ccnt = 0;
  always #25 clk = ~clk; // 50 ns period
  dtc_cpu u_cpu (.clk(clk), .rdata(rdata), .ptr(ptr), .addr(addr),
    .wr(wr), .rd(rd), .wdata(wdata));
  // first latch and word run tied: only their routing matters here
  dtc_timers DUT (.CORE_CLK(clk), .RST(rst), .STOP_RECOVER(stop),
    .REG_PTR(ptr), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .EXP_BANK_SWAP(swap),
    .TIMER_BANK_SEL(tsel), .WORD_RUN(1'b1),
    .COMPARATOR_INPUT_PIN(cmp_in), .PORT2_INPUT_PIN(p2_in),
    .PORT_LATCH_FIRST(1'b1), .PORT_LATCH_THIRD(lat3),
    .FIRST_OUTPUT_PIN(pin1), .THIRD_OUTPUT_PIN(pin3),
    .BYTE_TIMER_OUT(bout), .WORD_TIMER_OUT(wout),
    .CAPTURE_IRQ(cirq), .TIMEOUT_IRQ(tirq));
  // pulses last one cycle, so count them on every edge
  always @(posedge clk) begin
    if (tirq === 1'b1) tcnt++;
    if (cirq === 1'b1) ccnt++;
  end
  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_cpu.acc(1'b1, a, d, q);
  endtask : w
  task automatic r(input logic [7:0] a, input logic [7:0] e, input string n);
    logic [7:0] q;
    u_cpu.acc(1'b0, a, 8'h00, q);
    chk(n, e, q);
  endtask : r
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic t_reset;
    r(8'h00, 8'h00, "ctrl0");
    r(8'h01, 8'h00, "ctrl1");
    chk("pin1", 8'h01, {7'h00, pin1});
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs;
    for (int i = 4; i < 12; i++) w(8'(i), 8'ha5 ^ 8'(i));
    for (int i = 4; i < 8; i++) r(8'(i), 8'ha5 ^ 8'(i), "hold");
    for (int i = 8; i < 12; i++) r(8'(i), 8'h00, "capture");
    r(8'h02, 8'h00, "unmapped");
    cyc(1);
    u_cpu.ptr = 8'h73;
    u_cpu.addr = 8'h05;
    #1;
    chk("swap", 8'h01, {7'h00, swap});
    chk("tsel", 8'h00, {7'h00, tsel});
    cyc(1);
    u_cpu.ptr = 8'h70;
    w(8'h04, 8'h11);
    u_cpu.ptr = 8'h7d;
    r(8'h04, 8'ha1, "bank");
    $display("test registers done");
  endtask : t_regs
  task automatic t_timeout;
    int n;
    w(8'h00, 8'h20);
    w(8'h04, 8'h03);
    w(8'h05, 8'h03);
    for (int p = 0; p < 4; p++) begin
      n = tcnt;
      w(8'h00, 8'hc3 | 8'(p << 3));
      cyc(3 * (1 << p) - 1);
      chk("early", 8'(n), 8'(tcnt));
      cyc((1 << p) + 9);
      chk("late", 8'(n + 1), 8'(tcnt));
    end
    chk("pin1", {7'h00, bout}, {7'h00, pin1});
    r(8'h00, 8'h7b, "ctrl0");
    w(8'h00, 8'h5b);
    r(8'h00, 8'h7b, "keep");
    w(8'h00, 8'h7b);
    r(8'h00, 8'h5b, "clear");
    // modulo-n from reload three times out every fourth clock
    n = tcnt;
    w(8'h00, 8'h83);
    cyc(11);
    chk("modulo", 8'(n + 2), 8'(tcnt));
    w(8'h00, 8'h1b);
    w(8'h00, 8'h3b);
    cyc(1);
    stop = 1'b1;
    cyc(1);
    stop = 1'b0;
    r(8'h00, 8'h1a, "stop");
    $display("test timeout done");
  endtask : t_timeout
  // byte timer idle with start level zero, so its output stands at one
  task automatic t_pins;
    w(8'h01, 8'h4c);
    cyc(1);
    chk("wout", 8'h01, {7'h00, wout});
    chk("pin3", 8'h01, {7'h00, pin3});
    w(8'h01, 8'h48);
    cyc(1);
    chk("wout", 8'h00, {7'h00, wout});
    chk("pin3", 8'h00, {7'h00, pin3});
    w(8'h01, 8'h58);
    cyc(1);
    chk("pin3", 8'h01, {7'h00, pin3});
    w(8'h01, 8'h68);
    cyc(1);
    chk("pin3", 8'h00, {7'h00, pin3});
    w(8'h01, 8'h08);
    cyc(1);
    chk("pin3", 8'h01, {7'h00, pin3});
    $display("test pins done");
  endtask : t_pins
  task automatic t_demod;
    logic [7:0] q;
    int n;
    u_cpu.slow = 1'b1;
    w(8'h01, 8'ha0);
    w(8'h00, 8'h84);
    n = ccnt;
    cyc(10);
    cmp_in = 1'b1;
    cyc(30);
    cmp_in = 1'b0;
    cyc(20);
    chk("capirq", 8'(n + 2), 8'(ccnt));
    r(8'h01, 8'ha3, "flags");
    w(8'h01, 8'ha1);
    r(8'h01, 8'ha2, "fallclr");
    u_cpu.acc(1'b0, 8'h09, 8'h00, q);
    chk("wordhi", 8'h00, q);
    w(8'h01, 8'hc3);
    n = ccnt;
    p2_in = 1'b1;
    cyc(20);
    p2_in = 1'b0;
    cyc(20);
    chk("fallonly", 8'(n + 1), 8'(ccnt));
    r(8'h01, 8'hc1, "fallflag");
    $display("test demodulation done");
  endtask : t_demod
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_regs();
    t_timeout();
    t_pins();
    t_demod();
    wrap_up();
  end
  // the tests take under a thousand cycles; a hang stops here
  initial begin
    repeat (4000) @(posedge clk);
    err_count++;
    wrap_up();
  end
endmodule : dual_timer_control_capture_regs_tb
